// ### hdl/tbe_pkg.sv
// Package for the trace breakpoint event unit: field positions, codes and
// the packed structs that carry instruction, memory and control traffic.
// Assumes the core pipeline and fault sequencer share one clock with it.
package tbe_pkg;

   // Trace mode register: mode bit m, its event flag at m + TC_EV_OFS.
   localparam int TC_MODE_INSTR = 1;
   localparam int TC_MODE_BRANCH = 2;
   localparam int TC_MODE_CALL = 3;
   localparam int TC_MODE_RET = 4;
   localparam int TC_MODE_PRERET = 5;
   localparam int TC_MODE_SUPER = 6;
   localparam int TC_MODE_BKPT = 7;
   localparam int TC_EV_OFS = 16;
   localparam int TC_HW_IP0 = 24;
   localparam int TC_HW_DA0 = 26;
   localparam logic [31:0] TC_WR_MASK = 32'h0FFE_00FE;
   localparam logic [31:0] TC_EV_MASK = 32'h0FFE_0000;
   localparam logic [31:0] TC_RESET = 32'h0000_0000;

   // Comparator register layouts.
   localparam int IPB_EN_LSB = 0;
   localparam int IPB_ADDR_LSB = 2;
   localparam int BREAKPOINT_CONTROL_CH_STRIDE = 4;
   localparam int BREAKPOINT_CONTROL_EN_OFS = 2;
   localparam int SSP_TRACE_CTL = 0;
   localparam logic [31:0] CTL_RESET = 32'h0000_0000;

   // Data comparator access classes.
   localparam logic [1:0] DA_STORE = 2'h0;
   localparam logic [1:0] DA_LDST = 2'h1;
   localparam logic [1:0] DA_DATA_FETCH = 2'h2;
   localparam logic [1:0] DA_ANY = 2'h3;

   // Control register select codes for table load and system control.
   localparam logic [2:0] SEL_INSTR_ADDR_MATCH_0 = 3'h0;
   localparam logic [2:0] SEL_INSTR_ADDR_MATCH_1 = 3'h1;
   localparam logic [2:0] SEL_DATA_ADDR_MATCH_0 = 3'h2;
   localparam logic [2:0] SEL_DATA_ADDR_MATCH_1 = 3'h3;
   localparam logic [2:0] SEL_BREAKPOINT_CONTROL = 3'h4;
   localparam logic [2:0] SEL_SSP = 3'h5;

   typedef struct packed {
      logic valid;
      logic [31:0] ip;
      logic mark;
      logic fmark;
      logic branch_taken;
      logic call;
      logic bal;
      logic ret;
      logic svc_call;
      logic svc_ret;
   } tbe_insn_t;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic store;
      logic load;
      logic fetch;
   } tbe_mem_t;

   typedef struct packed {
      logic valid;
      logic [2:0] sel;
      logic [31:0] data;
   } tbe_ctlwr_t;

   typedef struct packed {
      logic te;
      logic tfp;
   } tbe_pcs_t;

   typedef struct packed {
      logic [31:0] tc;
      tbe_pcs_t pcs;
      tbe_pcs_t saved;
      logic [1:0][31:0] ipb;
      logic [1:0][31:0] dab;
      logic [31:0] breakpoint_control;
      logic trace_ctl;
      logic rtype_te;
      logic preret_defer;
      logic fault;
      logic preret_set;
      logic preret_cur;
   } tbe_state_t;

endpackage

// ### hdl/tbe_unit.sv
// Trace breakpoint event unit: event detection, trace flags, pending flag,
// the between-instruction trace fault decision and trace state handling on
// handler calls and returns.
// Assumes all inputs come from core logic on mclk_i; strobes are one cycle.
//
// Notes on behaviour
// [RL1] mark raises breakpoint event when mode enabled
// [RL2] fmark always raises a breakpoint event
// [RL3] Two instruction comparators match executed instruction pointer
// [RL4] Low two bits enable each instruction comparator
// [RL5] Two data comparators match address and class
// [RL6] Breakpoint control holds class and enable per comparator
// [RL7] Table load at init, system control later
// [RL8] Hardware match sets flags; fault after instruction
// [RL9] Implicit calls raise call event in call mode
// [RL10] Every satisfied mode sets its own flag
// [RL11] Event with trace enable sets pending flag
// [RL12] Event with enable clear leaves pending alone
// [RL13] All events recorded, so highest always signalled
// [RL14] Trace fault handler call clears trace enable
// [RL15] Pending clear lets next instruction proceed
// [RL16] Pending: enable clear clears flags, else fault
// [RL17] Prereturn deferred behind fault, raised on return
// [RL18] Interrupt entry saves controls, clears enable, pending
// [RL19] Interrupt return restores controls; fault follows
// [RL20] Restored pending overwrites the return event
// [RL21] Call event sets prereturn flag in frame
// [RL22] Supervisor call saves, loads and restores enable
// [RL23] Full address compare; writes apply afterwards
`timescale 1ns/1ps
module tbe_unit
   import tbe_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire tbe_insn_t insn_i,
   input wire tbe_mem_t mem_i,
   input wire logic implicit_call_i,
   input wire logic tf_call_i,
   input wire logic nontrace_fault_i,
   input wire logic fault_ret_i,
   input wire logic frame_preret_i,
   input wire logic intr_entry_i,
   input wire logic intr_ret_i,
   input wire tbe_pcs_t pc_restore_i,
   input wire logic svc_ret_te_i,
   input wire logic boundary_i,
   input wire logic tc_wr_i,
   input wire logic [31:0] tc_mask_i,
   input wire logic [31:0] tc_data_i,
   input wire tbe_ctlwr_t init_ctl_i,
   input wire tbe_ctlwr_t sysctl_i,
   output logic [31:0] tc_o,
   output tbe_pcs_t pcs_o,
   output tbe_pcs_t pc_saved_o,
   output logic rtype_te_o,
   output logic trace_fault_o,
   output logic preret_set_o,
   output logic preret_cur_o
);

   tbe_state_t st_q;
   tbe_state_t st_d;
   logic [1:0] ip_hit;
   logic [1:0] da_hit;
   logic [7:1] ev;
   logic any_ev;
   tbe_ctlwr_t ctl_wr;

   // Comparators read the registered values only, so a write reaches the
   // instructions and accesses that follow it, never the one beside it.
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_cmp
         logic [1:0] cls;
         logic cls_ok;
         assign cls = st_q.breakpoint_control[g*BREAKPOINT_CONTROL_CH_STRIDE +: 2];
         always_comb begin
            case (cls)
               DA_STORE: cls_ok = mem_i.store;
               DA_LDST: cls_ok = mem_i.store | mem_i.load;
               DA_DATA_FETCH: cls_ok = mem_i.store | mem_i.load
                  | mem_i.fetch;
               default: cls_ok = 1'b1;
            endcase
         end
         assign ip_hit[g] = insn_i.valid                     // RL3
            && (|st_q.ipb[g][IPB_EN_LSB +: 2])                // RL4
            && (insn_i.ip[31:IPB_ADDR_LSB]
               == st_q.ipb[g][31:IPB_ADDR_LSB]);
         assign da_hit[g] = mem_i.valid && cls_ok             // RL5
            && st_q.breakpoint_control[g*BREAKPOINT_CONTROL_CH_STRIDE + BREAKPOINT_CONTROL_EN_OFS]   // RL6
            && (mem_i.addr == st_q.dab[g]);                   // RL23
      end
   endgenerate

   // Per-mode events; each is gated by its own mode bit except fmark and
   // the hardware comparators, which fire regardless of the mode bits.
   always_comb begin
      ev = '0;
      ev[TC_MODE_INSTR] = insn_i.valid && st_q.tc[TC_MODE_INSTR];
      ev[TC_MODE_BRANCH] = insn_i.valid && insn_i.branch_taken
         && st_q.tc[TC_MODE_BRANCH];
      ev[TC_MODE_CALL] = st_q.tc[TC_MODE_CALL]                // RL9
         && ((insn_i.valid && (insn_i.call || insn_i.bal))
            || implicit_call_i || tf_call_i);
      ev[TC_MODE_RET] = insn_i.valid && insn_i.ret && st_q.tc[TC_MODE_RET];
      ev[TC_MODE_PRERET] = st_q.tc[TC_MODE_PRERET] && frame_preret_i
         && ((insn_i.valid && insn_i.ret && !nontrace_fault_i)
            || (fault_ret_i && st_q.preret_defer));           // RL17
      ev[TC_MODE_SUPER] = insn_i.valid && st_q.tc[TC_MODE_SUPER]
         && (insn_i.svc_call || insn_i.svc_ret);
      ev[TC_MODE_BKPT] = (insn_i.valid && insn_i.mark
         && st_q.tc[TC_MODE_BKPT])                            // RL1
         || (insn_i.valid && insn_i.fmark)                    // RL2
         || (|ip_hit) || (|da_hit);                           // RL8
   end

   assign any_ev = |ev;
   // Table load during initialization wins over a system control write.
   assign ctl_wr = init_ctl_i.valid ? init_ctl_i : sysctl_i;  // RL7

   // Next-state: writes, boundary decision, events, then handler changes.
   // Later steps override earlier ones, so a new event beats a clear.
   always_comb begin
      st_d = st_q;
      st_d.fault = 1'b0;
      st_d.preret_set = 1'b0;
      st_d.preret_cur = 1'b0;
      if (tc_wr_i) begin
         st_d.tc = ((st_q.tc & ~tc_mask_i) | (tc_data_i & tc_mask_i))
            & TC_WR_MASK;
      end
      if (ctl_wr.valid) begin
         case (ctl_wr.sel)
            SEL_INSTR_ADDR_MATCH_0: st_d.ipb[0] = ctl_wr.data;
            SEL_INSTR_ADDR_MATCH_1: st_d.ipb[1] = ctl_wr.data;
            SEL_DATA_ADDR_MATCH_0: st_d.dab[0] = ctl_wr.data;
            SEL_DATA_ADDR_MATCH_1: st_d.dab[1] = ctl_wr.data;
            SEL_BREAKPOINT_CONTROL: st_d.breakpoint_control = ctl_wr.data;
            SEL_SSP: st_d.trace_ctl = ctl_wr.data[SSP_TRACE_CTL];
            default: st_d.trace_ctl = st_q.trace_ctl;
         endcase
      end
      // Between instructions: nothing to do unless pending is set.
      if (boundary_i && st_q.pcs.tfp) begin                   // RL15
         st_d.pcs.tfp = 1'b0;
         if (st_q.pcs.te) begin
            st_d.fault = 1'b1;                                // RL16
         end else begin
            st_d.tc = st_d.tc & ~TC_EV_MASK;                  // RL16
         end
      end
      // Every mode met gets its flag, so the top-precedence one is kept.
      st_d.tc[TC_EV_OFS +: 8] = st_d.tc[TC_EV_OFS +: 8]
         | {ev, 1'b0};                                        // RL10 RL13
      st_d.tc[TC_HW_IP0 +: 2] = st_d.tc[TC_HW_IP0 +: 2] | ip_hit; // RL8
      st_d.tc[TC_HW_DA0 +: 2] = st_d.tc[TC_HW_DA0 +: 2] | da_hit; // RL8
      if (any_ev && st_q.pcs.te) begin
         st_d.pcs.tfp = 1'b1;                                 // RL11
      end
      // Prereturn masked by a coincident fault waits for that return.
      if (insn_i.valid && insn_i.ret && frame_preret_i && nontrace_fault_i
         && st_q.tc[TC_MODE_PRERET]) begin
         st_d.preret_defer = 1'b1;                            // RL17
      end else if (fault_ret_i) begin
         st_d.preret_defer = 1'b0;
      end
      if (ev[TC_MODE_CALL]) begin
         st_d.preret_set = 1'b1;                              // RL21
         st_d.preret_cur = insn_i.valid && insn_i.bal;        // RL21
      end
      if (insn_i.valid && insn_i.svc_call) begin
         st_d.rtype_te = st_q.pcs.te;                         // RL22
         st_d.pcs.te = st_q.trace_ctl;                        // RL22
      end
      if (insn_i.valid && insn_i.svc_ret) begin
         st_d.pcs.te = svc_ret_te_i;                          // RL22
      end
      // The trace handler runs untraced to avoid endless recursion.
      if (tf_call_i) begin
         st_d.rtype_te = st_q.pcs.te;
         st_d.pcs.te = 1'b0;                                  // RL14
      end
      if (intr_entry_i) begin
         st_d.saved = st_d.pcs;                               // RL18
         st_d.pcs = '0;                                       // RL18
      end
      // A restored pending flag replaces whatever the ret just produced.
      if (intr_ret_i || fault_ret_i) begin
         st_d.pcs = pc_restore_i;                             // RL19 RL20
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= '{tc: TC_RESET, pcs: '0, saved: '0,
            ipb: '{CTL_RESET, CTL_RESET}, dab: '{CTL_RESET, CTL_RESET},
            breakpoint_control: CTL_RESET, default: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign tc_o = st_q.tc;
   assign pcs_o = st_q.pcs;
   assign pc_saved_o = st_q.saved;
   assign rtype_te_o = st_q.rtype_te;
   assign trace_fault_o = st_q.fault;
   assign preret_set_o = st_q.preret_set;
   assign preret_cur_o = st_q.preret_cur;

   // Checks on the observable trace behaviour.
   logic quiet;
   assign quiet = !intr_entry_i && !intr_ret_i && !fault_ret_i
      && !tf_call_i && !(insn_i.valid && (insn_i.svc_call
      || insn_i.svc_ret));

   property p_fmark;
      @(posedge mclk_i) disable iff (!rst_n_i)
      insn_i.valid && insn_i.fmark |=> tc_o[TC_EV_OFS + TC_MODE_BKPT];
   endproperty
   a_fmark: assert property (p_fmark) else $error("fmark flag missing"); // RL2

   property p_mark;
      @(posedge mclk_i) disable iff (!rst_n_i)
      insn_i.valid && insn_i.mark && tc_o[TC_MODE_BKPT]
      |=> tc_o[TC_EV_OFS + TC_MODE_BKPT];
   endproperty
   a_mark: assert property (p_mark) else $error("mark flag missing"); // RL1

   property p_ip_hit;
      @(posedge mclk_i) disable iff (!rst_n_i)
      insn_i.valid && (|st_q.ipb[1][1:0])
      && insn_i.ip[31:2] == st_q.ipb[1][31:2] |=> tc_o[TC_HW_IP0 + 1];
   endproperty
   a_ip_hit: assert property (p_ip_hit) else $error("ip match lost"); // RL3

   property p_da_store;
      @(posedge mclk_i) disable iff (!rst_n_i)
      mem_i.valid && mem_i.store && st_q.breakpoint_control[2]
      && mem_i.addr == st_q.dab[0] |=> tc_o[TC_HW_DA0];
   endproperty
   a_da_store: assert property (p_da_store) else $error("da miss"); // RL5

   property p_pend_set;
      @(posedge mclk_i) disable iff (!rst_n_i)
      any_ev && pcs_o.te && quiet |=> pcs_o.tfp;
   endproperty
   a_pend_set: assert property (p_pend_set) else $error("no pend"); // RL11

   property p_pend_keep;
      @(posedge mclk_i) disable iff (!rst_n_i)
      any_ev && !pcs_o.te && quiet && !boundary_i
      |=> pcs_o.tfp == $past(pcs_o.tfp);
   endproperty
   a_pend_keep: assert property (p_pend_keep) else $error("tfp moved"); // RL12

   property p_fault;
      @(posedge mclk_i) disable iff (!rst_n_i)
      boundary_i |=> trace_fault_o == $past(pcs_o.tfp && pcs_o.te);
   endproperty
   a_fault: assert property (p_fault) else $error("fault wrong"); // RL16

   property p_clear;
      @(posedge mclk_i) disable iff (!rst_n_i)
      boundary_i && pcs_o.tfp && !pcs_o.te && !any_ev && !tc_wr_i
      |=> (tc_o & TC_EV_MASK) == 32'h0000_0000;
   endproperty
   a_clear: assert property (p_clear) else $error("flags kept"); // RL16

   property p_tf_call;
      @(posedge mclk_i) disable iff (!rst_n_i)
      tf_call_i && !intr_ret_i && !fault_ret_i |=> !pcs_o.te;
   endproperty
   a_tf_call: assert property (p_tf_call) else $error("te kept"); // RL14

   property p_intr;
      @(posedge mclk_i) disable iff (!rst_n_i)
      intr_entry_i && !intr_ret_i && !fault_ret_i
      |=> !pcs_o.te && !pcs_o.tfp;
   endproperty
   a_intr: assert property (p_intr) else $error("entry kept te"); // RL18

   property p_restore;
      @(posedge mclk_i) disable iff (!rst_n_i)
      intr_ret_i ##1 boundary_i && pcs_o.te && pcs_o.tfp
      |=> trace_fault_o;
   endproperty
   a_restore: assert property (p_restore) else $error("no fault"); // RL19

   property p_preret;
      @(posedge mclk_i) disable iff (!rst_n_i)
      ev[TC_MODE_CALL] |=> preret_set_o;
   endproperty
   a_preret: assert property (p_preret) else $error("no prereturn"); // RL21

   c_fault: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
      boundary_i && pcs_o.te && pcs_o.tfp ##1 trace_fault_o);
   c_da: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
      |da_hit);
   c_defer: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
      st_q.preret_defer && fault_ret_i && frame_preret_i);

endmodule

// ### tb/tbe_unit_tb.sv
// Self-checking bench for the trace breakpoint event unit.
// Assumes each effect shows on the outputs one cycle after its inputs.
`timescale 1ns/1ps
module tb;
   import tbe_pkg::*;
   logic mclk_i, rst_n_i, implicit_call_i, tf_call_i, nontrace_fault_i;
   logic fault_ret_i, frame_preret_i, intr_entry_i, intr_ret_i;
   logic svc_ret_te_i, boundary_i, tc_wr_i, rtype_te_o, trace_fault_o;
   logic preret_set_o, preret_cur_o, m_rt, m_cur, chk_on;
   logic [31:0] tc_mask_i, tc_data_i, tc_o, m_tc, a, d;
   tbe_insn_t insn_i;
   tbe_mem_t mem_i;
   tbe_pcs_t pc_restore_i, pcs_o, pc_saved_o, m_pcs, m_sv;
   tbe_ctlwr_t init_ctl_i, sysctl_i;
   logic [39:0] q[$];
   logic [39:0] e, got;
   int failures, comparisons;

   tbe_unit dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .insn_i(insn_i),
      .mem_i(mem_i), .implicit_call_i(implicit_call_i),
      .tf_call_i(tf_call_i), .nontrace_fault_i(nontrace_fault_i),
      .fault_ret_i(fault_ret_i), .frame_preret_i(frame_preret_i),
      .intr_entry_i(intr_entry_i), .intr_ret_i(intr_ret_i),
      .pc_restore_i(pc_restore_i), .svc_ret_te_i(svc_ret_te_i),
      .boundary_i(boundary_i), .tc_wr_i(tc_wr_i), .tc_mask_i(tc_mask_i),
      .tc_data_i(tc_data_i), .init_ctl_i(init_ctl_i), .sysctl_i(sysctl_i),
      .tc_o(tc_o), .pcs_o(pcs_o), .pc_saved_o(pc_saved_o),
      .rtype_te_o(rtype_te_o), .trace_fault_o(trace_fault_o),
      .preret_set_o(preret_set_o), .preret_cur_o(preret_cur_o));

   // The 20 MHz core clock.
   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end

   assign got = {tc_o, pcs_o, pc_saved_o, rtype_te_o, trace_fault_o,
      preret_set_o, preret_cur_o};

   task step();
      @(posedge mclk_i);
      #1;
   endtask

   // Drops every strobe; done once per check cycle so no input is
   // assigned twice in the same time step.
   task clr();
      insn_i = '0;
      mem_i = '0;
      implicit_call_i = 1'b0;
      tf_call_i = 1'b0;
      nontrace_fault_i = 1'b0;
      fault_ret_i = 1'b0;
      frame_preret_i = 1'b0;
      intr_entry_i = 1'b0;
      intr_ret_i = 1'b0;
      pc_restore_i = '0;
      svc_ret_te_i = 1'b0;
      boundary_i = 1'b0;
      tc_wr_i = 1'b0;
      init_ctl_i = '0;
      sysctl_i = '0;
   endtask

   // Notes the expected outputs for the cycle now under way.
   task chk(input logic tf, input logic pre);
      clr();
      q.push_back({m_tc, m_pcs, m_sv, m_rt, tf, pre, m_cur});
      m_cur = 1'b0;
      chk_on = 1'b1;
      step();
      chk_on = 1'b0;
   endtask

   // Sends the prepared event and expects the given flags.
   task ev(input logic [31:0] fl, input logic pre);
      step();
      m_tc = m_tc | fl;
      if (fl != '0 && m_pcs.te)
         m_pcs.tfp = 1'b1;
      chk(1'b0, pre);
   endtask

   task wtc(input logic [31:0] mk, input logic [31:0] dt);
      tc_wr_i = 1'b1;
      tc_mask_i = mk;
      tc_data_i = dt;
      step();
      m_tc = (m_tc & ~(mk & TC_WR_MASK)) | (dt & mk & TC_WR_MASK);
      chk(1'b0, 1'b0);
   endtask

   task rest(input logic te, input logic tfp);
      intr_ret_i = 1'b1;
      pc_restore_i = {te, tfp};
      step();
      m_pcs = {te, tfp};
      chk(1'b0, 1'b0);
   endtask

   task ctl(input logic ini, input logic [2:0] sel, input logic [31:0] dt);
      if (ini)
         init_ctl_i = {1'b1, sel, dt};
      else
         sysctl_i = {1'b1, sel, dt};
      step();
      chk(1'b0, 1'b0);
   endtask

   // Decision point between instructions.
   task bnd();
      logic f;
      boundary_i = 1'b1;
      step();
      f = m_pcs.te & m_pcs.tfp;
      if (m_pcs.tfp && !m_pcs.te)
         m_tc = m_tc & ~TC_EV_MASK;
      m_pcs.tfp = 1'b0;
      chk(f, 1'b0);
   endtask

   task end_of_test();
      if (failures == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Compares each noted expectation with the outputs at mid-cycle.
   always @(negedge mclk_i) begin
      if (chk_on) begin
         e = q.pop_front();
         comparisons++;
         if (got !== e) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, e);
         end
      end else if (rst_n_i === 1'b1 && trace_fault_o !== 1'b0) begin
         failures++;
         $display("unexpected at %0t: stray trace fault", $time);
      end
   end

   // The tests need under two hundred cycles; this cuts a hang short.
   initial begin
      #(4000 * 50);
      failures++;
      end_of_test();
   end

   initial begin
      clr();
      chk_on = 1'b0;
      failures = 0;
      comparisons = 0;
      m_tc = TC_RESET;
      m_pcs = '0;
      m_sv = '0;
      m_rt = 1'b0;
      m_cur = 1'b0;
      tc_mask_i = '0;
      tc_data_i = '0;
      rst_n_i = 1'b0;
      void'($urandom(58));
      repeat (4) @(posedge mclk_i);
      #1;
      rst_n_i = 1'b1;
      chk(1'b0, 1'b0);
      wtc('1, '1);
      wtc('1, '0);
      insn_i.valid = 1'b1;
      insn_i.mark = 1'b1;
      ev('0, 1'b0);
      wtc(32'h0000_0088, 32'h0000_0088);
      insn_i.valid = 1'b1;
      insn_i.mark = 1'b1;
      ev(32'h0080_0000, 1'b0);
      rest(1'b0, 1'b1);
      bnd();
      wtc(32'h0000_0080, '0);
      insn_i.valid = 1'b1;
      insn_i.fmark = 1'b1;
      ev(32'h0080_0000, 1'b0);
      wtc(32'h0000_0080, 32'h0000_0080);
      rest(1'b1, 1'b0);
      bnd();
      insn_i.valid = 1'b1;
      insn_i.mark = 1'b1;
      insn_i.call = 1'b1;
      ev(32'h0088_0000, 1'b1);
      bnd();
      a = $urandom & ~32'h0000_0003;
      ctl(1'b1, SEL_INSTR_ADDR_MATCH_0, a | 32'h0000_0001);
      ctl(1'b1, SEL_INSTR_ADDR_MATCH_1, a ^ 32'h0000_0010);
      wtc(TC_EV_MASK, '0);
      insn_i.valid = 1'b1;
      insn_i.ip = a;
      ev(32'h0180_0000, 1'b0);
      insn_i.valid = 1'b1;
      insn_i.ip = a ^ 32'h0000_0010;
      ev('0, 1'b0);
      bnd();
      d = $urandom;
      ctl(1'b0, SEL_DATA_ADDR_MATCH_0, d);
      for (int c = 0; c < 4; c++) begin
         ctl(1'b0, SEL_BREAKPOINT_CONTROL, 32'(c) | 32'h0000_0004);
         for (int k = 0; k < 4; k++) begin
            wtc(TC_EV_MASK, '0);
            mem_i = {1'b1, d, k == 0, k == 1, k == 2};
            ev((k <= c) ? 32'h0480_0000 : '0, 1'b0);
         end
      end
      wtc(TC_EV_MASK, '0);
      mem_i = {1'b1, d ^ 32'h8000_0000, 3'h0};
      ev('0, 1'b0);
      ctl(1'b0, SEL_BREAKPOINT_CONTROL, 32'h0000_0003);
      mem_i = {1'b1, d, 3'h4};
      ev('0, 1'b0);
      bnd();
      wtc(TC_EV_MASK, '0);
      implicit_call_i = 1'b1;
      ev(32'h0008_0000, 1'b1);
      insn_i.valid = 1'b1;
      insn_i.bal = 1'b1;
      m_cur = 1'b1;
      ev(32'h0008_0000, 1'b1);
      wtc(32'h0000_0008, '0);
      tf_call_i = 1'b1;
      step();
      m_rt = m_pcs.te;
      m_pcs.te = 1'b0;
      chk(1'b0, 1'b0);
      rest(1'b1, 1'b1);
      intr_entry_i = 1'b1;
      step();
      m_sv = m_pcs;
      m_pcs = '0;
      chk(1'b0, 1'b0);
      rest(1'b1, 1'b1);
      bnd();
      wtc(32'h0000_0010, 32'h0000_0010);
      insn_i.valid = 1'b1;
      insn_i.ret = 1'b1;
      intr_ret_i = 1'b1;
      pc_restore_i = 2'h2;
      step();
      m_tc = m_tc | 32'h0010_0000;
      m_pcs = 2'h2;
      chk(1'b0, 1'b0);
      bnd();
      wtc(32'h0000_0010, '0);
      ctl(1'b0, SEL_SSP, '0);
      insn_i.valid = 1'b1;
      insn_i.svc_call = 1'b1;
      step();
      m_rt = 1'b1;
      m_pcs.te = 1'b0;
      chk(1'b0, 1'b0);
      insn_i.valid = 1'b1;
      insn_i.svc_ret = 1'b1;
      svc_ret_te_i = 1'b1;
      step();
      m_pcs.te = 1'b1;
      chk(1'b0, 1'b0);
      rest(1'b0, 1'b0);
      wtc(32'h0000_0020, 32'h0000_0020);
      insn_i.valid = 1'b1;
      insn_i.ret = 1'b1;
      frame_preret_i = 1'b1;
      nontrace_fault_i = 1'b1;
      ev('0, 1'b0);
      fault_ret_i = 1'b1;
      frame_preret_i = 1'b1;
      ev(32'h0020_0000, 1'b0);
      // A reset in mid-run must also disarm the loaded comparators.
      rst_n_i = 1'b0;
      step();
      rst_n_i = 1'b1;
      m_tc = TC_RESET;
      m_pcs = '0;
      m_sv = '0;
      m_rt = 1'b0;
      chk(1'b0, 1'b0);
      insn_i.valid = 1'b1;
      insn_i.ip = a;
      ev('0, 1'b0);
      end_of_test();
   end
endmodule
